// >>> rtl/scm_top.sv
// supply and clock integrity monitor with wishbone control/status register
`timescale 1ns/1ps
`include "scm_regs.svh"

module scm_top
    import scm_pkg::*;
#(
    parameter int RST_PULSE_NS = `SCM_RST_PULSE_NS,
    parameter int PULSE_W = 16
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SCM_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic opt_uvr_enable_i,
    input wire logic [1:0] opt_uvr_level_i,
    input wire logic opt_css_enable_i,
    input wire logic opt_pll_enable_i,
    input wire logic opt_long_delay_i,
    input wire logic uvr_below_rise_i,
    input wire logic uvr_below_fall_i,
    input wire logic aux_supply_cmp_i,
    input wire logic aux_pin_cmp_i,
    input wire logic osc_present_i,
    input wire logic osc_glitch_i,
    input wire logic rst_pin_i,
    input wire logic wdg_underflow_i,
    input wire logic cpu_imask_i,
    input wire logic aux_irq_ack_i,
    input wire logic wait_i,
    input wire logic halt_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_n_o,
    output logic sys_reset_o,
    output logic [1:0] uvr_level_o,
    output logic uvr_enable_o,
    output logic safe_osc_en_o,
    output logic clk_sel_safe_o,
    output logic clk_filter_en_o,
    output logic clk_gate_o,
    output logic aux_irq_o,
    output logic css_irq_o,
    output logic wake_o
);

    localparam int PULSE_CYC = (RST_PULSE_NS * `SCM_CLK_MHZ + 999) / 1000;
    localparam int NSYNC = 7;
    localparam logic [NSYNC-1:0] SYNC_IDLE = `SCM_SYNC_IDLE;

    generate
        if (PULSE_CYC < 1 || PULSE_CYC >= (1 << PULSE_W))
        begin : g_bad
            $error("reset pulse count does not fit its counter");
        end
    endgenerate

    // two-flop synchronisers for every asynchronous analog or pin input;
    // reset to idle levels so no false clock loss or pin reset follows reset
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign async_in = {rst_pin_i, osc_glitch_i, osc_present_i, aux_pin_cmp_i,
                       aux_supply_cmp_i, uvr_below_fall_i, uvr_below_rise_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    sync_a[gi] <= SYNC_IDLE[gi];
                    sync_b[gi] <= SYNC_IDLE[gi];
                end
                else if (ce_i)
                begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    logic below_rise;
    logic below_fall;
    logic aux_sup;
    logic aux_pin;
    logic osc_ok;
    logic osc_glitch;
    logic pin_low;
    assign below_rise = sync_b[0];
    assign below_fall = sync_b[1];
    assign aux_sup = sync_b[2];
    assign aux_pin = sync_b[3];
    assign osc_ok = sync_b[4];
    assign osc_glitch = sync_b[5];
    assign pin_low = ~sync_b[6];

    // control register bits and pending interrupt flags
    logic src_sel;
    logic aux_ie;
    logic css_ie;
    logic uvr_flag;
    logic wdg_flag;
    logic css_det;
    logic aux_pend;
    logic css_pend;

    // hysteresis: enter on falling threshold, leave above rising threshold
    logic uv;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            uv <= 1'b0;
        else if (ce_i)
        begin
            if (!opt_uvr_enable_i)
                uv <= 1'b0;
            else if (uv)
                uv <= below_rise;
            else
                uv <= below_fall;
        end
    end

    assign uvr_level_o = opt_uvr_level_i;
    assign uvr_enable_o = opt_uvr_enable_i;

    // reset sequence: active phase, then the option-selected delay
    scm_rst_t rst_state;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [`SCM_DLY_W-1:0] dly_cnt;
    logic wdg_hit;
    logic ext_hit;
    logic [1:0] drv_hist;
    assign wdg_hit = wdg_underflow_i;
    // the pin echoes our own drive through the synchroniser for two cycles
    assign ext_hit = pin_low && (rst_state == RS_IDLE) && !(|drv_hist);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drv_hist <= '1;
        else if (ce_i)
            drv_hist <= {drv_hist[0], rst_state != RS_IDLE};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_state <= RS_ACTIVE;
            pulse_cnt <= PULSE_W'(PULSE_CYC);
            dly_cnt <= `SCM_DLY_W'(0);
        end
        else if (ce_i)
        begin
            case (rst_state)
                RS_IDLE:
                begin
                    if (uv || wdg_hit || ext_hit)
                    begin
                        rst_state <= RS_ACTIVE;
                        pulse_cnt <= PULSE_W'(PULSE_CYC);
                    end
                end
                RS_ACTIVE:
                begin
                    if (wdg_hit)
                        pulse_cnt <= PULSE_W'(PULSE_CYC);
                    else if (pulse_cnt != PULSE_W'(0))
                        pulse_cnt <= pulse_cnt - PULSE_W'(1);
                    if (!uv && !wdg_hit && pulse_cnt == PULSE_W'(0))
                    begin
                        rst_state <= RS_DELAY;
                        dly_cnt <= opt_long_delay_i ? `SCM_DLY_LONG
                                                    : `SCM_DLY_SHORT;
                    end
                end
                RS_DELAY:
                begin
                    if (uv || wdg_hit)
                    begin
                        rst_state <= RS_ACTIVE;
                        pulse_cnt <= PULSE_W'(PULSE_CYC);
                    end
                    else if (dly_cnt == `SCM_DLY_W'(1))
                        rst_state <= RS_IDLE;
                    else
                        dly_cnt <= dly_cnt - `SCM_DLY_W'(1);
                end
                default:
                    rst_state <= RS_ACTIVE;
            endcase
        end
    end

    assign sys_reset_o = (rst_state != RS_IDLE);
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_n_o = (rst_state == RS_IDLE);

    // auxiliary detector flag, qualified by the undervoltage option
    logic aux_raw;
    logic aux_flag;
    logic aux_prev;
    assign aux_raw = src_sel ? aux_pin : aux_sup;
    assign aux_flag = opt_uvr_enable_i & aux_raw;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            aux_prev <= 1'b0;
        else if (ce_i)
            aux_prev <= aux_flag;
    end

    // wishbone slave, one wait state
    logic bus_req;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [7:0] ctrl_val;
    logic next_aux_ie;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == `SCM_ADR_CTRL);
    assign rd_ctrl = bus_req && !wb_we_i && (wb_adr_i == `SCM_ADR_CTRL);
    assign next_aux_ie = wr_ctrl ? wb_dat_i[`SCM_BIT_AUX_IE] : aux_ie;

    always_comb
    begin
        ctrl_val = `SCM_CTRL_RESET;
        ctrl_val[`SCM_BIT_SRC] = src_sel;
        ctrl_val[`SCM_BIT_AUX_IE] = aux_ie;
        ctrl_val[`SCM_BIT_AUX_FLAG] = aux_flag;
        ctrl_val[`SCM_BIT_UVR_FLAG] = uvr_flag;
        ctrl_val[`SCM_BIT_CSS_IE] = css_ie;
        ctrl_val[`SCM_BIT_CSS_DET] = css_det & opt_css_enable_i;
        ctrl_val[`SCM_BIT_WDG_FLAG] = wdg_flag;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `SCM_WORD_ZERO;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                if (wb_adr_i == `SCM_ADR_CTRL)
                    wb_dat_o <= {24'h00_0000, ctrl_val};
                else if (wb_adr_i == `SCM_ADR_OPTS)
                    wb_dat_o <= {27'h000_0000, opt_long_delay_i,
                                 opt_pll_enable_i, opt_css_enable_i,
                                 opt_uvr_level_i};
                else
                    wb_dat_o <= `SCM_WORD_ZERO;
            end
        end
    end

    // software configuration; kept through halt, defaults only on reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_sel <= 1'b0;
            aux_ie <= 1'b0;
            css_ie <= 1'b0;
        end
        else if (ce_i && wr_ctrl)
        begin
            src_sel <= wb_dat_i[`SCM_BIT_SRC];
            aux_ie <= wb_dat_i[`SCM_BIT_AUX_IE];
            css_ie <= wb_dat_i[`SCM_BIT_CSS_IE];
        end
    end

    // reset cause flags: hardware set wins over a software zero write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            uvr_flag <= 1'b0;
            wdg_flag <= 1'b0;
        end
        else if (ce_i)
        begin
            if (uv)
                uvr_flag <= 1'b1;
            else if (wr_ctrl && !wb_dat_i[`SCM_BIT_UVR_FLAG])
                uvr_flag <= 1'b0;
            if (uv)
                wdg_flag <= 1'b0;
            else if (wdg_hit)
                wdg_flag <= 1'b1;
            else if (wr_ctrl && !wb_dat_i[`SCM_BIT_WDG_FLAG])
                wdg_flag <= 1'b0;
        end
    end

    // auxiliary pending interrupt
    logic aux_edge;
    logic aux_arm;
    assign aux_edge = (aux_flag != aux_prev) && !sys_reset_o;
    assign aux_arm = !aux_ie && next_aux_ie && aux_flag;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            aux_pend <= 1'b0;
        else if (ce_i)
        begin
            if (!opt_uvr_enable_i)
                aux_pend <= 1'b0;
            else if ((aux_edge && aux_ie) || aux_arm)
                aux_pend <= 1'b1;
            else if (aux_irq_ack_i)
                aux_pend <= 1'b0;
        end
    end

    // clock guard: main, safe, or off while halted
    scm_clk_t clk_state;
    logic guard_on;
    assign guard_on = opt_css_enable_i && !halt_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clk_state <= CK_MAIN;
        else if (ce_i)
        begin
            case (clk_state)
                CK_MAIN:
                begin
                    if (!guard_on && opt_css_enable_i)
                        clk_state <= CK_OFF;
                    else if (guard_on && !osc_ok)
                        clk_state <= CK_SAFE;
                end
                CK_SAFE:
                begin
                    if (!guard_on)
                        clk_state <= CK_OFF;
                    else if (osc_ok)
                        clk_state <= CK_MAIN;
                end
                CK_OFF:
                begin
                    if (!halt_i)
                        clk_state <= CK_MAIN;
                end
                default:
                    clk_state <= CK_MAIN;
            endcase
        end
    end

    assign clk_sel_safe_o = (clk_state == CK_SAFE);
    assign safe_osc_en_o = guard_on;
    assign clk_filter_en_o = opt_pll_enable_i && guard_on;
    assign clk_gate_o = !(clk_filter_en_o && osc_glitch);

    // detected flag clears on a read once the main clock is back
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            css_det <= 1'b0;
            css_pend <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!opt_css_enable_i)
            begin
                css_det <= 1'b0;
                css_pend <= 1'b0;
            end
            else if (clk_state == CK_SAFE)
            begin
                css_det <= 1'b1;
                if (!css_det && css_ie)
                    css_pend <= 1'b1;
            end
            else if (rd_ctrl)
            begin
                css_det <= 1'b0;
                css_pend <= 1'b0;
            end
        end
    end

    assign aux_irq_o = aux_pend && aux_ie && !cpu_imask_i
                       && opt_uvr_enable_i;
    assign css_irq_o = css_pend && css_ie && !cpu_imask_i;
    assign wake_o = wait_i && (aux_irq_o || css_irq_o);

    chk_uv_pin_low: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        uv |=> !rst_pin_oe_n_o)
        else $error("reset pin not driven during undervoltage");

    chk_wdg_pulse_len: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (wdg_hit && !uv) |=> !rst_pin_oe_n_o [*8])
        else $error("watchdog reset pulse too short");

    chk_uv_static: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        uv |=> sys_reset_o)
        else $error("system left reset during undervoltage");

    chk_aux_gated: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        !opt_uvr_enable_i |-> !ctrl_val[`SCM_BIT_AUX_FLAG] && !aux_irq_o)
        else $error("aux detector active with option off");

    chk_aux_toggle: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (aux_edge && aux_ie && opt_uvr_enable_i) |=> aux_pend)
        else $error("aux toggle lost its interrupt");

    chk_aux_in_delay: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (sys_reset_o && !aux_pend && !aux_arm) |=> !aux_pend)
        else $error("aux interrupt raised during reset delay");

    chk_safe_switch: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (clk_state == CK_MAIN && guard_on && !osc_ok)
        |=> clk_sel_safe_o ##1 css_det)
        else $error("no switch to safe oscillator");

    chk_switch_back: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (clk_sel_safe_o && guard_on && osc_ok) |=> !clk_sel_safe_o)
        else $error("no switch back to main clock");

    chk_halt_off: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        halt_i |-> !safe_osc_en_o ##1 !clk_sel_safe_o)
        else $error("clock guard active in halt");

    chk_irq_mask: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (cpu_imask_i || !aux_ie) |-> !aux_irq_o)
        else $error("aux interrupt delivered while masked");

    chk_det_clear: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (rd_ctrl && clk_state != CK_SAFE) |=> !css_det)
        else $error("detected flag not cleared by read");

    chk_wdg_flag: assert property (@(posedge clk_i)
        disable iff (rst_i || !ce_i)
        (wdg_hit && !uv) |=> wdg_flag)
        else $error("watchdog flag not set");

endmodule

// >>> common/scm_regs.svh
// register map, field positions and timing counts of the integrity monitor
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

`define SCM_ADR_W 8
`define SCM_ADR_CTRL 8'h00
`define SCM_ADR_OPTS 8'h04

`define SCM_BIT_SRC 3'd7
`define SCM_BIT_AUX_IE 3'd6
`define SCM_BIT_AUX_FLAG 3'd5
`define SCM_BIT_UVR_FLAG 3'd4
`define SCM_BIT_CSS_IE 3'd2
`define SCM_BIT_CSS_DET 3'd1
`define SCM_BIT_WDG_FLAG 3'd0

`define SCM_CTRL_RESET 8'h00
`define SCM_WORD_ZERO 32'h0000_0000
// idle levels of the synchronised inputs: clock present, reset pin released
`define SCM_SYNC_IDLE 7'h50

`define SCM_DLY_W 13
`define SCM_DLY_SHORT 13'h0100
`define SCM_DLY_LONG 13'h1000

`define SCM_CLK_MHZ 100
`define SCM_RST_PULSE_NS 1000

`endif

// >>> common/scm_pkg.sv
// types shared by the integrity monitor
package scm_pkg;
    typedef enum logic [1:0] {RS_IDLE, RS_ACTIVE, RS_DELAY} scm_rst_t;
    typedef enum logic [1:0] {CK_MAIN, CK_SAFE, CK_OFF} scm_clk_t;
endpackage

// >>> test/scm_far_model.sv
// far-side model: supply comparators, main oscillator, reset pin, cpu ack
`timescale 1ns/1ps
module scm_far_model (
    input wire logic clk_i,
    input wire logic [7:0] supply_i,
    input wire logic [7:0] epin_i,
    input wire logic osc_ok_i,
    input wire logic ext_rst_i,
    input wire logic auto_ack_i,
    input wire logic aux_irq_i,
    input wire logic pin_oe_n_i,
    output logic below_rise_o,
    output logic below_fall_o,
    output logic aux_sup_o,
    output logic aux_pin_o,
    output logic osc_o,
    output logic pin_o,
    output logic ack_o,
    output logic [7:0] ack_cnt_o
);
    logic [1:0] dly;
    initial
    begin
        aux_sup_o = 1'b0;
        aux_pin_o = 1'b0;
        dly = 2'd0;
        ack_o = 1'b0;
        ack_cnt_o = 8'h00;
    end
    assign below_rise_o = supply_i < 8'd70;
    assign below_fall_o = supply_i < 8'd60;
    assign osc_o = osc_ok_i;
    // open-drain pin with pull-up: high unless someone pulls it low
    assign pin_o = (pin_oe_n_i === 1'b0 || ext_rst_i) ? 1'b0 : 1'b1;
    // hysteretic comparators: set below 100, clear at 110 and above
    always @(supply_i)
    begin
        if (supply_i < 8'd100)
            aux_sup_o = 1'b1;
        else if (supply_i >= 8'd110)
            aux_sup_o = 1'b0;
    end
    always @(epin_i)
    begin
        if (epin_i < 8'd100)
            aux_pin_o = 1'b1;
        else if (epin_i >= 8'd110)
            aux_pin_o = 1'b0;
    end
    // cpu enters the service routine a few cycles after the request
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        if (dly == 2'd1 && aux_irq_i === 1'b1)
        begin
            ack_o <= 1'b1;
            ack_cnt_o <= ack_cnt_o + 8'h01;
        end
        if (dly != 2'd0)
            dly <= dly - 2'd1;
        else if (aux_irq_i === 1'b1 && auto_ack_i && !ack_o)
            dly <= 2'd3;
    end
endmodule

// >>> test/scm_top_test.sv
// self-checking bench of the supply and clock integrity monitor
`timescale 1ns/1ps
`include "scm_regs.svh"
module scm_top_test;
    import scm_pkg::*;
    localparam int PCYC = 20;
    logic clk_i, rst_i, cyc, stb, we, ack, wdg, imask, aack, waitm, haltm;
    logic uen, clock_fail_guard, pll, osc_ok, glitch, ext_rst, src, sf, pf, ce;
    logic [1:0] lvl;
    logic [3:0] sel;
    logic [7:0] adr, rd, supply, epin, acnt, base, tog;
    logic [31:0] wdat, wb_dat_o, rv;
    logic br, bf, asup, apin, oscp, pin, oe_n, sysr, uen_o, safe, selsf;
    logic filt, gate, airq, cirq, wake, wb_ack_o, pdat;
    logic [1:0] lvl_o;
    int error_cnt, num_checks, seed, n, i;
    scm_top #(.RST_PULSE_NS(PCYC * 10)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .opt_uvr_enable_i(uen), .opt_uvr_level_i(lvl),
        .opt_css_enable_i(clock_fail_guard), .opt_pll_enable_i(pll),
        .opt_long_delay_i(1'b0), .uvr_below_rise_i(br), .uvr_below_fall_i(bf),
        .aux_supply_cmp_i(asup), .aux_pin_cmp_i(apin), .osc_present_i(oscp),
        .osc_glitch_i(glitch), .rst_pin_i(pin), .wdg_underflow_i(wdg),
        .cpu_imask_i(imask), .aux_irq_ack_i(ack), .wait_i(waitm),
        .halt_i(haltm), .rst_pin_o(pdat), .rst_pin_oe_n_o(oe_n),
        .sys_reset_o(sysr), .uvr_level_o(lvl_o), .uvr_enable_o(uen_o),
        .safe_osc_en_o(safe), .clk_sel_safe_o(selsf),
        .clk_filter_en_o(filt), .clk_gate_o(gate), .aux_irq_o(airq),
        .css_irq_o(cirq), .wake_o(wake));
    scm_far_model far (.clk_i(clk_i), .supply_i(supply), .epin_i(epin),
        .osc_ok_i(osc_ok), .ext_rst_i(ext_rst), .auto_ack_i(aack),
        .aux_irq_i(airq), .pin_oe_n_i(oe_n), .below_rise_o(br),
        .below_fall_o(bf), .aux_sup_o(asup), .aux_pin_o(apin), .osc_o(oscp),
        .pin_o(pin), .ack_o(ack), .ack_cnt_o(acnt));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20)
        begin
            error_cnt++;
            print_verdict();
        end
    endtask
    task automatic wait_run;
        int k;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (sysr !== 1'b0 && k < 2000);
        if (k >= 2000)
        begin
            error_cnt++;
            print_verdict();
        end
    endtask
    function automatic logic nflag(input logic [7:0] v, input logic old);
        return (v < 8'd100) ? 1'b1 : ((v >= 8'd110) ? 1'b0 : old);
    endfunction
    // moves one comparator input and counts the expected flag toggles
    task automatic setv(input logic p, input logic [7:0] v);
        logic f;
        f = p ? pf : sf;
        if (p)
            epin <= v;
        else
            supply <= v;
        if (p == src && nflag(v, f) !== f)
            tog++;
        if (p)
            pf = nflag(v, f);
        else
            sf = nflag(v, f);
        repeat (12) @(posedge clk_i);
    endtask
    task automatic wdg_pulse;
        @(posedge clk_i);
        wdg <= 1'b1;
        @(posedge clk_i);
        wdg <= 1'b0;
        n = 0;
        repeat (600)
        begin
            @(posedge clk_i);
            n = n + (pin === 1'b0);
        end
    endtask
    initial
    begin
        {rst_i, uen, clock_fail_guard, pll, osc_ok, sel, lvl, supply, epin} =
            {1'b1, 4'hf, 4'hf, 2'd2, 8'd120, 8'd120};
        {cyc, stb, we, adr, wdat, glitch, ext_rst, wdg} = 0;
        {imask, aack, waitm, haltm, src, sf, pf, tog} = 0;
        ce = 1'b1;
        seed = 32'hef99f115;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({sysr, oe_n, pdat}, 3'b100);
        wait_run();
        chk(pin, 1'b1);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd, `SCM_CTRL_RESET);
        wb(0, `SCM_ADR_OPTS, 0);
        chk(rd, 8'h0e);
        wb(0, 8'h08, 0);
        chk(rd, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            lvl <= i[1:0];
            @(posedge clk_i);
            @(posedge clk_i);
            chk({uen_o, lvl_o}, {1'b1, i[1:0]});
        end
        lvl <= 2'd2;
        $display("test options done");
        for (i = 0; i < 8; i++)
        begin
            rv = $random(seed);
            wb(1, `SCM_ADR_CTRL, rv[7:0]);
            wb(0, `SCM_ADR_CTRL, 0);
            chk(rd, rv[7:0] & 8'hc4);
        end
        wb(1, `SCM_ADR_CTRL, 8'h00);
        sel <= 4'he;
        wb(1, `SCM_ADR_CTRL, 8'hc4);
        sel <= 4'hf;
        wb(1, `SCM_ADR_OPTS, 8'h00);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd, 8'h00);
        $display("test register access done");
        aack <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            src = i[0];
            wb(1, `SCM_ADR_CTRL, {src, 7'h40});
            base = acnt;
            tog = 0;
            for (n = 0; n < 12; n++)
            begin
                rv = (n < 4) ? {8'd100, 8'd110, 8'd109, 8'd99} >> (8 * n)
                    : 32'd90 + ($random(seed) & 32'h1f);
                setv(src, rv[7:0]);
                wb(0, `SCM_ADR_CTRL, 0);
                chk(rd[5], src ? pf : sf);
                chk(acnt, base + tog);
            end
            setv(src, 8'd120);
        end
        $display("test aux toggles done");
        wb(1, `SCM_ADR_CTRL, 8'h40);
        aack <= 1'b0;
        imask <= 1'b1;
        setv(0, 8'd95);
        chk(airq, 1'b0);
        imask <= 1'b0;
        waitm <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({airq, wake}, 2'b11);
        waitm <= 1'b0;
        aack <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(airq, 1'b0);
        wb(1, `SCM_ADR_CTRL, 8'h00);
        base = acnt;
        wb(1, `SCM_ADR_CTRL, 8'h40);
        repeat (10) @(posedge clk_i);
        setv(0, 8'd120);
        chk(acnt, base + 8'd2);
        setv(0, 8'd95);
        base = acnt;
        $display("test aux enable done");
        setv(0, 8'd50);
        chk({sysr, pin}, 2'b10);
        repeat (30) @(posedge clk_i);
        chk({sysr, pin}, 2'b10);
        supply <= 8'd120;
        sf = 1'b0;
        wait_run();
        repeat (12) @(posedge clk_i);
        chk({acnt, airq}, {base, 1'b0});
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd & 8'h30, 8'h10);
        wb(1, `SCM_ADR_CTRL, 8'h00);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd, 8'h00);
        wdg_pulse();
        chk(n >= PCYC + 256, 1'b1);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd & 8'h11, 8'h01);
        setv(0, 8'd50);
        supply <= 8'd120;
        wait_run();
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd & 8'h11, 8'h10);
        wb(1, `SCM_ADR_CTRL, 8'h44);
        ce <= 1'b0;
        wdg <= 1'b1;
        @(posedge clk_i);
        wdg <= 1'b0;
        @(posedge clk_i);
        ce <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(sysr, 1'b0);
        ext_rst <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(sysr, 1'b1);
        ext_rst <= 1'b0;
        wait_run();
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd & 8'h11, 8'h00);
        uen <= 1'b0;
        setv(0, 8'd50);
        chk({sysr, airq, uen_o}, 3'b000);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd, 8'h44);
        setv(0, 8'd120);
        uen <= 1'b1;
        wb(1, `SCM_ADR_CTRL, 8'h04);
        $display("test resets done");
        pll <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({safe, filt}, 2'b10);
        pll <= 1'b1;
        haltm <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({safe, filt}, 2'b00);
        haltm <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({safe, filt}, 2'b11);
        glitch <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(gate, 1'b0);
        pll <= 1'b0;
        @(posedge clk_i);
        chk(gate, 1'b1);
        pll <= 1'b1;
        glitch <= 1'b0;
        osc_ok <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk({selsf, cirq}, 2'b11);
        wb(0, `SCM_ADR_CTRL, 0);
        chk(rd, 8'h06);
        osc_ok <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(selsf, 1'b0);
        wb(0, `SCM_ADR_CTRL, 0);
        wb(0, `SCM_ADR_CTRL, 0);
        chk({rd, cirq}, {8'h04, 1'b0});
        wb(1, `SCM_ADR_CTRL, 8'h00);
        osc_ok <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk({selsf, cirq}, 2'b10);
        osc_ok <= 1'b1;
        $display("test clock guard done");
        print_verdict();
    end
endmodule
